// ===== verilog/owr_defs.vh
// owr_defs.vh: offsets, field positions and reset values of the hidden
// window and address remap register block.
// assumes byte addressing on a 32-bit classic wishbone slave.
`ifndef OWR_DEFS_VH
`define OWR_DEFS_VH

`define OWR_ADDR_W 8
`define OWR_OFF_CTRL 8'h58
`define OWR_OFF_HID_LOW 8'h5c
`define OWR_OFF_HID_UBASE 8'h60
`define OWR_OFF_HID_ULIM 8'h64
`define OWR_OFF_RMP_CTRL 8'h68
`define OWR_OFF_RMP_PUBASE 8'h6c
`define OWR_OFF_RMP_SLBASE 8'h70
`define OWR_OFF_RMP_SUBASE 8'h74
`define OWR_OFF_RMP_SLLIM 8'h78
`define OWR_OFF_RMP_SULIM 8'h7c

`define OWR_HID_EN_BIT 5
`define OWR_RMP_EN_BIT 3
`define OWR_WIDE_FLAG 4'h1
`define OWR_LOW_LIM_MSB 31
`define OWR_LOW_LIM_LSB 20
`define OWR_LOW_BASE_MSB 15
`define OWR_LOW_BASE_LSB 4
`define OWR_HID_LOW_RESET 32'h00010001
`define OWR_ZERO32 32'h00000000

`endif

// ===== verilog/owr_reg32.v
// owr_reg32.v: one 32-bit register with per-byte write enables and a
// write mask that leaves read-only bits at their reset value.
// assumes a single clock with synchronous active-high reset.
`timescale 1ns/100ps
module owr_reg32 #(
  parameter [31:0] RESET_VAL = 32'h00000000,
  parameter [31:0] WR_MASK = 32'hffffffff
) (
  input wire clk_i, // core clock
  input wire rst_i, // synchronous reset
  input wire wr_i, // write strobe
  input wire [3:0] sel_i, // byte enables
  input wire [31:0] dat_i, // write data
  output wire [31:0] q_o // stored value
);
  reg [31:0] val_ff;
  reg [31:0] nxt_val;
  integer i;

  always @* begin
    nxt_val = val_ff;
    for (i = 0; i < 32; i = i + 1) begin
      if (wr_i && sel_i[i / 8] && WR_MASK[i])
        nxt_val[i] = dat_i[i];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i)
      val_ff <= RESET_VAL;
    else
      val_ff <= nxt_val;
  end

  assign q_o = val_ff;
endmodule

// ===== verilog/owr_addr_decode.v
// owr_addr_decode.v: pure address checks of the hidden window and the
// non-transparent remap, registered for one cycle of latency.
// assumes register values are stable while a lookup is in flight.
`timescale 1ns/100ps
module owr_addr_decode (
  input wire clk_i, // core clock
  input wire rst_i, // synchronous reset
  input wire req_i, // lookup request
  input wire [63:0] addr_i, // memory address
  input wire hid_en_i, // hidden window enable
  input wire [63:0] hid_base_i, // hidden window base
  input wire [63:0] hid_lim_i, // hidden window limit top
  input wire rmp_en_i, // remap enable
  input wire [63:0] pri_base_i, // primary base
  input wire [63:0] sec_base_i, // secondary base
  input wire [63:0] sec_lim_i, // secondary limit top
  output reg done_o, // result valid pulse
  output reg hidden_o, // address in hidden window
  output reg remapped_o, // address was translated
  output reg [63:0] addr_o // translated address
);
  wire hid_hit;
  wire sec_hit;
  wire [63:0] xlat;

  assign hid_hit = hid_en_i && (addr_i >= hid_base_i) && (addr_i <= hid_lim_i); // RULE2
  assign sec_hit = rmp_en_i && (addr_i >= sec_base_i) && (addr_i <= sec_lim_i);
  assign xlat = addr_i - sec_base_i + pri_base_i; // RULE18

  always @(posedge clk_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      hidden_o <= 1'b0;
      remapped_o <= 1'b0;
      addr_o <= 64'h0000000000000000;
    end else begin
      done_o <= req_i;
      if (req_i) begin
        hidden_o <= hid_hit; // RULE17
        remapped_o <= sec_hit && !hid_hit;
        addr_o <= sec_hit ? xlat : addr_i; // RULE7
      end
    end
  end
endmodule

// ===== verilog/owr_top.v
// owr_top.v: hidden memory window and non-transparent address remap
// registers with their lookup path.
// assumes a classic wishbone master on clk_i and a bridge core that
// asks for lookups on a req/done port and honours the claim answer.
//
// Operation
// RULE1 - hidden window hits are never claimed
// RULE2 - window decoding only while enable is one
// RULE3 - 0x05C holds low base and limit
// RULE4 - wide flags in 0x05C read 0x1
// RULE5 - 0x060 holds upper window base
// RULE6 - 0x064 holds upper window limit
// RULE7 - remap range addresses go elsewhere
// RULE8 - 0x068 bit 3 enables remapping
// RULE9 - 0x068 bits 31:20 primary low base
// RULE10 - 0x06C holds upper primary base
// RULE11 - 0x070 bits 31:20 secondary low base
// RULE12 - 0x074 holds upper secondary base
// RULE13 - 0x078 bits 31:20 secondary low limit
// RULE14 - 0x07C holds upper secondary limit
// RULE15 - 0x058 bit 5 enables hidden window
// RULE16 - hits: unsupported primary, abort secondary
// RULE17 - inclusive 64-bit compare, 1 MB grain
// RULE18 - translate offset from secondary onto primary
`timescale 1ns/100ps
`include "owr_defs.vh"
module owr_top (
  input wire clk_i, // core clock, 25 MHz
  input wire rst_i, // synchronous reset, active high
  input wire wb_cyc_i, // wishbone cycle
  input wire wb_stb_i, // wishbone strobe
  input wire wb_we_i, // wishbone write
  input wire [7:0] wb_adr_i, // wishbone byte address
  input wire [3:0] wb_sel_i, // wishbone byte enables
  input wire [31:0] wb_dat_i, // wishbone write data
  output reg [31:0] wb_dat_o, // wishbone read data
  output reg wb_ack_o, // wishbone acknowledge
  output reg wb_err_o, // wishbone error on unmapped address
  input wire lk_req_i, // lookup request pulse
  input wire lk_from_pri_i, // request came from the primary side
  input wire [63:0] lk_addr_i, // memory address to decode
  output reg lk_done_o, // lookup answer pulse
  output reg lk_claim_o, // bridge may claim the transaction
  output reg lk_unsup_o, // answer as unsupported request
  output reg lk_mabort_o, // terminate with master abort
  output reg lk_remap_o, // address was remapped
  output reg [63:0] lk_addr_o // address to forward
);
  wire bus_req;
  wire wr_go;
  reg hit_map;
  reg [31:0] rd_mux;
  wire [9:0] reg_wr;
  wire [31:0] q_ctrl;
  wire [31:0] q_hlow;
  wire [31:0] q_hubase;
  wire [31:0] q_hulim;
  wire [31:0] q_rctrl;
  wire [31:0] q_pubase;
  wire [31:0] q_slbase;
  wire [31:0] q_subase;
  wire [31:0] q_sllim;
  wire [31:0] q_sulim;
  wire [7:0] offs [0:9];
  reg pri_ff;
  wire dec_done;
  wire dec_hidden;
  wire dec_remap;
  wire [63:0] dec_addr;

  // one cycle answer; ack drops after one cycle so back to back works
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign wr_go = bus_req && wb_we_i && hit_map;

  assign offs[0] = `OWR_OFF_CTRL;
  assign offs[1] = `OWR_OFF_HID_LOW;
  assign offs[2] = `OWR_OFF_HID_UBASE;
  assign offs[3] = `OWR_OFF_HID_ULIM;
  assign offs[4] = `OWR_OFF_RMP_CTRL;
  assign offs[5] = `OWR_OFF_RMP_PUBASE;
  assign offs[6] = `OWR_OFF_RMP_SLBASE;
  assign offs[7] = `OWR_OFF_RMP_SUBASE;
  assign offs[8] = `OWR_OFF_RMP_SLLIM;
  assign offs[9] = `OWR_OFF_RMP_SULIM;

  genvar g;
  generate
    for (g = 0; g < 10; g = g + 1) begin : g_wr
      assign reg_wr[g] = wr_go && (wb_adr_i == offs[g]);
    end
  endgenerate

  always @* begin
    hit_map = (wb_adr_i >= `OWR_OFF_CTRL) && (wb_adr_i <= `OWR_OFF_RMP_SULIM) &&
      (wb_adr_i[1:0] == 2'b00);
  end

  // only the hidden window enable lives in the control word here
  owr_reg32 #(.RESET_VAL(`OWR_ZERO32), .WR_MASK(32'h00000020)) u_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .wr_i(reg_wr[0]), .sel_i(wb_sel_i),
    .dat_i(wb_dat_i), .q_o(q_ctrl)); // RULE15
  // wide flags are masked off, so they keep their reset value of 0x1
  owr_reg32 #(.RESET_VAL(`OWR_HID_LOW_RESET), .WR_MASK(32'hfff0fff0)) u_hlow (
    .clk_i(clk_i), .rst_i(rst_i), .wr_i(reg_wr[1]), .sel_i(wb_sel_i),
    .dat_i(wb_dat_i), .q_o(q_hlow)); // RULE3 RULE4
  owr_reg32 #(.RESET_VAL(`OWR_ZERO32)) u_hubase (
    .clk_i(clk_i), .rst_i(rst_i), .wr_i(reg_wr[2]), .sel_i(wb_sel_i),
    .dat_i(wb_dat_i), .q_o(q_hubase)); // RULE5
  owr_reg32 #(.RESET_VAL(`OWR_ZERO32)) u_hulim (
    .clk_i(clk_i), .rst_i(rst_i), .wr_i(reg_wr[3]), .sel_i(wb_sel_i),
    .dat_i(wb_dat_i), .q_o(q_hulim)); // RULE6
  owr_reg32 #(.RESET_VAL(`OWR_ZERO32), .WR_MASK(32'hfff00008)) u_rctrl (
    .clk_i(clk_i), .rst_i(rst_i), .wr_i(reg_wr[4]), .sel_i(wb_sel_i),
    .dat_i(wb_dat_i), .q_o(q_rctrl)); // RULE8 RULE9
  owr_reg32 #(.RESET_VAL(`OWR_ZERO32)) u_pubase (
    .clk_i(clk_i), .rst_i(rst_i), .wr_i(reg_wr[5]), .sel_i(wb_sel_i),
    .dat_i(wb_dat_i), .q_o(q_pubase)); // RULE10
  owr_reg32 #(.RESET_VAL(`OWR_ZERO32), .WR_MASK(32'hfff00000)) u_slbase (
    .clk_i(clk_i), .rst_i(rst_i), .wr_i(reg_wr[6]), .sel_i(wb_sel_i),
    .dat_i(wb_dat_i), .q_o(q_slbase)); // RULE11
  owr_reg32 #(.RESET_VAL(`OWR_ZERO32)) u_subase (
    .clk_i(clk_i), .rst_i(rst_i), .wr_i(reg_wr[7]), .sel_i(wb_sel_i),
    .dat_i(wb_dat_i), .q_o(q_subase)); // RULE12
  owr_reg32 #(.RESET_VAL(`OWR_ZERO32), .WR_MASK(32'hfff00000)) u_sllim (
    .clk_i(clk_i), .rst_i(rst_i), .wr_i(reg_wr[8]), .sel_i(wb_sel_i),
    .dat_i(wb_dat_i), .q_o(q_sllim)); // RULE13
  owr_reg32 #(.RESET_VAL(`OWR_ZERO32)) u_sulim (
    .clk_i(clk_i), .rst_i(rst_i), .wr_i(reg_wr[9]), .sel_i(wb_sel_i),
    .dat_i(wb_dat_i), .q_o(q_sulim)); // RULE14

  always @* begin
    case (wb_adr_i)
      `OWR_OFF_CTRL: rd_mux = q_ctrl;
      `OWR_OFF_HID_LOW: rd_mux = q_hlow;
      `OWR_OFF_HID_UBASE: rd_mux = q_hubase;
      `OWR_OFF_HID_ULIM: rd_mux = q_hulim;
      `OWR_OFF_RMP_CTRL: rd_mux = q_rctrl;
      `OWR_OFF_RMP_PUBASE: rd_mux = q_pubase;
      `OWR_OFF_RMP_SLBASE: rd_mux = q_slbase;
      `OWR_OFF_RMP_SUBASE: rd_mux = q_subase;
      `OWR_OFF_RMP_SLLIM: rd_mux = q_sllim;
      `OWR_OFF_RMP_SULIM: rd_mux = q_sulim;
      default: rd_mux = `OWR_ZERO32;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= `OWR_ZERO32;
    end else begin
      wb_ack_o <= bus_req && hit_map;
      wb_err_o <= bus_req && !hit_map;
      if (bus_req && hit_map && !wb_we_i)
        wb_dat_o <= rd_mux;
    end
  end

  // base is aligned down and limit up to 1 MB within the 64-bit space
  owr_addr_decode u_dec (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_i(lk_req_i),
    .addr_i(lk_addr_i),
    .hid_en_i(q_ctrl[`OWR_HID_EN_BIT]),
    .hid_base_i({q_hubase, q_hlow[15:4], 20'h00000}), // RULE17
    .hid_lim_i({q_hulim, q_hlow[31:20], 20'hfffff}), // RULE17
    .rmp_en_i(q_rctrl[`OWR_RMP_EN_BIT]),
    .pri_base_i({q_pubase, q_rctrl[31:20], 20'h00000}),
    .sec_base_i({q_subase, q_slbase[31:20], 20'h00000}),
    .sec_lim_i({q_sulim, q_sllim[31:20], 20'hfffff}),
    .done_o(dec_done),
    .hidden_o(dec_hidden),
    .remapped_o(dec_remap),
    .addr_o(dec_addr)
  );

  always @(posedge clk_i) begin
    if (rst_i)
      pri_ff <= 1'b0;
    else if (lk_req_i)
      pri_ff <= lk_from_pri_i;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      lk_done_o <= 1'b0;
      lk_claim_o <= 1'b0;
      lk_unsup_o <= 1'b0;
      lk_mabort_o <= 1'b0;
      lk_remap_o <= 1'b0;
      lk_addr_o <= 64'h0000000000000000;
    end else begin
      lk_done_o <= dec_done;
      if (dec_done) begin
        lk_claim_o <= !dec_hidden; // RULE1
        lk_unsup_o <= dec_hidden && pri_ff; // RULE16
        lk_mabort_o <= dec_hidden && !pri_ff; // RULE16
        lk_remap_o <= dec_remap;
        lk_addr_o <= dec_addr;
      end
    end
  end
endmodule

// ===== dv/owr_agent.sv
// owr_agent.sv: bridge-side requester that issues address lookups.
// assumes the bench raises go_i for one cycle per lookup.
`timescale 1ns/100ps
module owr_agent (
  input wire clk_i, // core clock
  input wire go_i, // issue a lookup
  input wire [63:0] addr_i, // address to look up
  input wire pri_i, // origin is primary side
  output logic lk_req_o = 1'b0, // lookup request
  output logic [63:0] lk_addr_o = 64'h0, // lookup address
  output logic lk_from_pri_o = 1'b0 // lookup origin
);
  // idle address and origin lines flip each cycle so a stale value is never mistaken for data
  always @(posedge clk_i) begin
    lk_req_o <= go_i;
    lk_addr_o <= go_i ? addr_i : ~lk_addr_o;
    lk_from_pri_o <= go_i ? pri_i : ~lk_from_pri_o;
  end
endmodule

// ===== dv/owr_top_asserts.sv
// owr_top_asserts.sv: port-level checks of register bus and lookups.
// assumes no write to 0x58 while a lookup is in flight.
`timescale 1ns/100ps
module owr_top_chk (
  input wire clk_i, // clock
  input wire rst_i, // reset
  input wire wb_cyc_i, // cycle
  input wire wb_stb_i, // strobe
  input wire wb_we_i, // write
  input wire [7:0] wb_adr_i, // address
  input wire [3:0] wb_sel_i, // byte enables
  input wire [31:0] wb_dat_i, // write data
  input wire [31:0] wb_dat_o, // read data
  input wire wb_ack_o, // ack
  input wire wb_err_o, // error
  input wire lk_req_i, // lookup request
  input wire lk_from_pri_i, // origin
  input wire lk_done_o, // answer
  input wire lk_claim_o, // claim
  input wire lk_unsup_o, // unsupported
  input wire lk_mabort_o, // master abort
  input wire lk_remap_o // remapped
);
  logic en_ff;
  always @(posedge clk_i) begin
    if (rst_i) en_ff <= 1'b0;
    else if (wb_ack_o && wb_we_i && wb_adr_i == 8'h58 && wb_sel_i[0]) en_ff <= wb_dat_i[5];
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
    |=> wb_ack_o ^ wb_err_o) else $error("bus request not answered");
  a_answer_single: assert property (wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o)
    else $error("bus answer longer than one cycle");
  a_err_unmapped: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o &&
    (wb_adr_i < 8'h58 || wb_adr_i > 8'h7c || wb_adr_i[1:0] != 2'h0) |=> wb_err_o)
    else $error("unmapped address not refused");
  a_wide_flags: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h5c
    |-> wb_dat_o[19:16] == 4'h1 && wb_dat_o[3:0] == 4'h1) else $error("wide flags wrong");
  a_rmp_reserved: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h68
    |-> wb_dat_o[19:4] == 16'h0000 && wb_dat_o[2:0] == 3'h0) else $error("reserved set");
  a_sec_reserved: assert property (wb_ack_o && !wb_we_i &&
    (wb_adr_i == 8'h70 || wb_adr_i == 8'h78) |-> wb_dat_o[19:0] == 20'h00000)
    else $error("secondary reserved bits set");
  a_lookup_latency: assert property (lk_req_i |-> ##2 lk_done_o)
    else $error("lookup answer late");
  a_off_claims: assert property (lk_done_o && !en_ff |-> lk_claim_o)
    else $error("decode while window disabled");
  a_hit_answer: assert property (lk_done_o && !lk_claim_o |-> !lk_remap_o &&
    lk_unsup_o == $past(lk_from_pri_i, 2) && lk_mabort_o != lk_unsup_o)
    else $error("hidden hit answered wrongly");
  a_claim_clean: assert property (lk_done_o && lk_claim_o |-> !lk_unsup_o && !lk_mabort_o)
    else $error("claimed lookup flagged");
endmodule
bind owr_top owr_top_chk i_owr_top_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .lk_req_i,
  .lk_from_pri_i, .lk_done_o, .lk_claim_o, .lk_unsup_o, .lk_mabort_o, .lk_remap_o);

// ===== dv/owr_top_tb.sv
// owr_top_tb.sv: register and lookup bench with a reference model.
// assumes owr_agent issues lookups and the checker is bound to owr_top.
`timescale 1ns/100ps
module owr_top_tb;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, go = 0, gpri = 0;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] dat = 0, u;
  logic [63:0] ga = 0, pr [10];
  wire [31:0] wb_dat_o;
  wire [63:0] lk_a, lk_addr_o;
  wire wb_ack_o, wb_err_o, lk_req, lk_pri, lk_done_o, lk_claim_o, lk_unsup_o, lk_mabort_o;
  wire lk_remap_o;
  int err_total = 0, compares = 0;
  logic [31:0] r [10];
  logic [67:0] q [$];
  always #20 clk_i = ~clk_i;
  owr_agent i_owr_agent (.clk_i(clk_i), .go_i(go), .addr_i(ga), .pri_i(gpri),
    .lk_req_o(lk_req), .lk_addr_o(lk_a), .lk_from_pri_o(lk_pri));
  owr_top i_owr_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .lk_req_i(lk_req), .lk_from_pri_i(lk_pri),
    .lk_addr_i(lk_a), .lk_done_o(lk_done_o), .lk_claim_o(lk_claim_o),
    .lk_unsup_o(lk_unsup_o), .lk_mabort_o(lk_mabort_o), .lk_remap_o(lk_remap_o),
    .lk_addr_o(lk_addr_o));
  task conclude;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [67:0] g, input logic [67:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  function automatic logic [31:0] wm(int i);
    case (i)
      0: return 32'h00000020;
      1: return 32'hfff0fff0;
      4: return 32'hfff00008;
      6, 8: return 32'hfff00000;
      default: return 32'hffffffff;
    endcase
  endfunction
  function automatic logic [67:0] lk(logic [63:0] a, logic fp);
    logic [63:0] hb, hl, sb, sl, pb;
    logic hit, inr;
    hb = {r[2], r[1][15:4], 20'h00000};
    hl = {r[3], r[1][31:20], 20'hfffff};
    pb = {r[5], r[4][31:20], 20'h00000};
    sb = {r[7], r[6][31:20], 20'h00000};
    sl = {r[9], r[8][31:20], 20'hfffff};
    hit = r[0][5] && a >= hb && a <= hl;
    inr = r[4][3] && a >= sb && a <= sl;
    return {!hit, hit && fp, hit && !fp, inr && !hit, inr ? a - sb + pb : a};
  endfunction
  task wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
    output logic [31:0] o, output logic e);
    int n;
    n = 0;
    cyc <= 1; stb <= 1; we <= w; adr <= a; sel <= s; dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
    o = wb_dat_o;
    e = wb_err_o;
    if (n >= 20) chk(0, 1);
    cyc <= 0; stb <= 0;
    @(posedge clk_i);
  endtask
  task wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] o, bm;
    logic e, mp;
    int i;
    mp = a >= 8'h58 && a <= 8'h7c && a[1:0] == 2'h0;
    i = int'(a - 8'h58) >> 2;
    wb(1, a, s, d, o, e);
    chk(e, !mp);
    bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    if (mp) r[i] = (r[i] & ~(bm & wm(i))) | (d & bm & wm(i));
  endtask
  task rd_all;
    logic [31:0] o;
    logic e;
    for (int i = 0; i < 10; i++) begin
      wb(0, 8'(8'h58 + 4 * i), 4'hf, $urandom, o, e);
      chk({e, o}, {1'b0, r[i]});
    end
  endtask
  task mreset;
    foreach (r[k]) r[k] = 32'h00000000;
    r[1] = 32'h00010001;
  endtask
  always @(posedge clk_i) begin
    if (lk_done_o === 1'b1) begin
      if (q.size() == 0) chk(0, 1);
      else chk({lk_claim_o, lk_unsup_o, lk_mabort_o, lk_remap_o, lk_addr_o}, q.pop_front());
    end
  end
  initial begin
    #400000;
    err_total++;
    conclude;
  end
  initial begin
    void'($urandom(592));
    mreset;
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    rd_all;
    $display("test reset values done");
    repeat (40) wr(8'(8'h58 + 4 * ($urandom % 10)), 4'($urandom), $urandom);
    wr(8'h80, 4'hf, 32'hffffffff);
    wr(8'h54, 4'hf, 32'hffffffff);
    wr(8'h5e, 4'hf, 32'hffffffff);
    rd_all;
    $display("test register access done");
    u = $urandom % 4;
    wr(8'h5c, 4'hf, 32'h00500030);
    wr(8'h60, 4'hf, u); wr(8'h64, 4'hf, u); wr(8'h6c, 4'hf, u ^ 1); wr(8'h74, 4'hf, u);
    wr(8'h70, 4'hf, 32'h00400000); wr(8'h78, 4'hf, 32'h02000000); wr(8'h7c, 4'hf, u);
    pr = '{{u, 32'h002fffff}, {u, 32'h00300000}, {u, 32'h005fffff}, {u, 32'h00600000},
      {u, 32'h003fffff}, {u, 32'h00400000}, {u, 32'h020fffff}, {u, 32'h02100000},
      {u + 1, 32'h00300000}, {u, $urandom}};
    for (int e = 0; e < 4; e++) begin
      wr(8'h58, 4'h1, {26'h0, e[0], 5'h00});
      wr(8'h68, 4'hf, {12'h7f0, 16'h0000, e[1], 3'h0});
      foreach (pr[k]) begin
        gpri <= 1'($urandom);
        q.push_back(lk(pr[k], gpri));
        go <= 1; ga <= pr[k];
        @(posedge clk_i);
        q[q.size() - 1] = lk(pr[k], gpri);
      end
      go <= 0;
      repeat (5) @(posedge clk_i);
      chk(q.size(), 0);
    end
    $display("test lookups done");
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    mreset;
    rd_all;
    $display("test second reset done");
    conclude;
  end
endmodule
